// ==== pafs_map.svh ====
// Register select codes, reset values and field positions for the port pin multiplexer.
`ifndef PAFS_MAP_SVH
`define PAFS_MAP_SVH

`define PAFS_SEL_PA_DATA   3'h0
`define PAFS_SEL_PA_DIR    3'h1
`define PAFS_SEL_OP_DATA   3'h2
`define PAFS_SEL_OP_DIR    3'h3
`define PAFS_SEL_ADSEL     3'h4
`define PAFS_SEL_CHSEL     3'h5
`define PAFS_SEL_CLKMODE   3'h6

`define PAFS_LATCH_RST     1'b0
`define PAFS_PA_DIR_RST    8'hff
`define PAFS_OP_DIR_RST    4'hf
`define PAFS_ADSEL_RST     4'h0
`define PAFS_CHSEL_RST     3'h0
`define PAFS_CLKMODE_RST   8'h00
`define PAFS_RDATA_RST     8'h00

`define PAFS_ADSEL_ALLDIG  4'h8
`define PAFS_CLKMODE_WMASK 8'hf1
`define PAFS_CLKM_EXT      7
`define PAFS_CLKM_OSC      6
`define PAFS_CLKM_EXTS     5
`define PAFS_CLKM_OSCS     4
`define PAFS_CLKM_GAIN     0

`define PAFS_OSC_MAIN_IN   0
`define PAFS_OSC_MAIN_OUT  1
`define PAFS_OSC_SUB_IN    2
`define PAFS_OSC_SUB_OUT   3

`endif

// ==== pafs_pkg.sv ====
// Types shared by the port pin multiplexer modules.
`default_nettype none
`include "pafs_map.svh"

package pafs_pkg;

    typedef logic [7:0] pafs_byte_t;

    typedef enum logic [2:0] {
        PAFS_PA_DATA = `PAFS_SEL_PA_DATA,
        PAFS_PA_DIR  = `PAFS_SEL_PA_DIR,
        PAFS_OP_DATA = `PAFS_SEL_OP_DATA,
        PAFS_OP_DIR  = `PAFS_SEL_OP_DIR,
        PAFS_ADSEL   = `PAFS_SEL_ADSEL,
        PAFS_CHSEL   = `PAFS_SEL_CHSEL,
        PAFS_CLKMODE = `PAFS_SEL_CLKMODE
    } pafs_sel_t;

endpackage : pafs_pkg

`default_nettype wire

// ==== pafs_pin_cell.sv ====
// One port pin: output latch, pin synchroniser, driver and read selection.
`default_nettype none
`include "pafs_map.svh"

module pafs_pin_cell
    import pafs_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic latch_wr,
    input  wire logic latch_d,
    input  wire logic dir_in,
    input  wire logic owned,
    input  wire logic alt_en,
    input  wire logic alt_val,
    input  wire logic alt_and,
    input  wire logic pin_i,
    output logic      pin_o,
    output logic      pin_oe,
    output logic      rd_val
);

    logic latch_q;
    logic sync1_q;
    logic sync2_q;
    logic drive;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_q <= `PAFS_LATCH_RST; // [RQ13]
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            if (latch_wr) begin
                latch_q <= latch_d; // [RQ9]
            end
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
        end
    end

    // The peripheral signal is merged with the latch, so an AND pin needs latch 1 and an OR pin latch 0.
    assign drive  = alt_en ? (alt_and ? (alt_val & latch_q) : (alt_val | latch_q)) : latch_q; // [RQ14]
    // Input mode or a pin taken by the oscillator or converter keeps the buffer off.
    assign pin_oe = ~dir_in & ~owned; // [RQ13] [RQ8]
    assign pin_o  = pin_oe & drive;
    assign rd_val = owned ? 1'b0 : (dir_in ? sync2_q : latch_q); // [RQ9]

endmodule // pafs_pin_cell

`default_nettype wire

// ==== pafs_top.sv ====
// Multiplexed port pins: an analog-capable 8-bit port and a 4-bit oscillator-capable port.
// Summary of operation
// [RQ1] Input functions: software sets direction bit to 1.
// [RQ2] Output functions: direction 0, latch 0 or 1.
// [RQ3] Analog pin role from selection, channel, direction.
// [RQ4] Analog input at selected channel is conversion target.
// [RQ5] Unselected analog input idles; analog output is prohibited.
// [RQ6] Software selects oscillator modes in clock mode register.
// [RQ7] Clock mode register resets to zero, pins stay ports.
// [RQ8] Oscillator modes make direction and latch irrelevant.
// [RQ9] Input bits: writes hit latch, reads see pin.
// [RQ10] Single-bit op reads, modifies, writes all eight bits.
// [RQ11] Untargeted input bits latch their current pin level.
// [RQ12] Rewrite latch when switching a bit to output.
// [RQ13] Output mode drives latch; input mode buffer off; reset clears.
// [RQ14] Peripheral output combines with latch level on the pin.
`default_nettype none
`include "pafs_map.svh"

module pafs_top
    import pafs_pkg::*;
#(
    parameter logic [7:0] PA_ALT_AND_MASK = 8'h00
)
(
    input  wire logic       CORE_CLK,
    input  wire logic       RSTN,
    input  wire logic       ACC_WR,
    input  wire logic       ACC_BIT,
    input  wire logic [2:0] ACC_SEL,
    input  wire logic [7:0] ACC_WDATA,
    input  wire logic [2:0] ACC_BITNUM,
    input  wire logic       ACC_BITVAL,
    output logic      [7:0] ACC_RDATA,
    input  wire logic [7:0] PA_ALT_EN,
    input  wire logic [7:0] PA_ALT_OUT,
    input  wire logic [7:0] PA_PIN_I,
    output logic      [7:0] PA_PIN_O,
    output logic      [7:0] PA_PIN_OE,
    input  wire logic [3:0] OP_PIN_I,
    output logic      [3:0] OP_PIN_O,
    output logic      [3:0] OP_PIN_OE,
    output logic      [7:0] ANA_INPUT_EN,
    output logic      [7:0] ANA_CONV_TGT,
    output logic            ANA_CFG_ERR,
    output logic            CLK_MAIN_OSC_EN,
    output logic            CLK_MAIN_EXT_EN,
    output logic            CLK_SUB_OSC_EN,
    output logic            CLK_SUB_EXT_EN,
    output logic            CLK_GAIN_HIGH
);

    logic [7:0] pa_dir_q;
    logic [7:0] pa_dir_d;
    logic [3:0] op_dir_q;
    logic [3:0] op_dir_d;
    logic [3:0] adsel_q;
    logic [3:0] adsel_d;
    logic [2:0] chsel_q;
    logic [2:0] chsel_d;
    logic [7:0] clkm_q;
    logic [7:0] clkm_d;
    logic [7:0] rdata_q;
    logic [7:0] ana_en_q;
    logic [7:0] ana_tgt_q;
    logic       ana_err_q;

    logic [7:0] pa_rd;
    logic [3:0] op_rd;
    logic [7:0] cur_rd;
    logic [7:0] bit_mask;
    logic [7:0] wr_data;
    logic       wr_any;
    logic [7:0] ana_mask;
    logic       adsel_bad;
    logic [7:0] ana_tgt;
    logic [3:0] osc_own;
    logic       osc_main;
    logic       ext_main;
    logic       osc_sub;
    logic       ext_sub;

    // Pins from the first selected step upward are analog; codes above all-digital are illegal.
    function automatic logic [7:0] adsel_decode(input logic [3:0] code);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m[i] = (code <= `PAFS_ADSEL_ALLDIG) && (4'(i) >= code);
        end
        return m;
    endfunction

    // Every register comes in as an argument, so the read path follows each register change.
    function automatic logic [7:0] read_sel(input logic [2:0] sel,
                                            input logic [7:0] pa,
                                            input logic [3:0] op,
                                            input logic [7:0] pa_dir,
                                            input logic [3:0] op_dir,
                                            input logic [3:0] adsel,
                                            input logic [2:0] chsel,
                                            input logic [7:0] clkm);
        logic [7:0] r;
        r = 8'h00;
        unique case (sel)
            `PAFS_SEL_PA_DATA: r = pa;
            `PAFS_SEL_PA_DIR:  r = pa_dir;
            `PAFS_SEL_OP_DATA: r = {4'h0, op};
            `PAFS_SEL_OP_DIR:  r = {4'h0, op_dir};
            `PAFS_SEL_ADSEL:   r = {4'h0, adsel};
            `PAFS_SEL_CHSEL:   r = {5'h00, chsel};
            `PAFS_SEL_CLKMODE: r = clkm;
            default:           r = 8'h00;
        endcase
        return r;
    endfunction

    // The whole byte is read first, so input bits carry their pin level into the write.
    assign cur_rd   = read_sel(ACC_SEL, pa_rd, op_rd, pa_dir_q, op_dir_q, adsel_q, chsel_q,
                               clkm_q); // [RQ10] [RQ11]
    assign bit_mask = 8'h01 << ACC_BITNUM;
    assign wr_data  = ACC_BIT ? ((cur_rd & ~bit_mask) | (ACC_BITVAL ? bit_mask : 8'h00))
                              : ACC_WDATA; // [RQ10]
    assign wr_any   = ACC_WR | ACC_BIT;

    assign pa_dir_d = (wr_any && ACC_SEL == `PAFS_SEL_PA_DIR) ? wr_data : pa_dir_q;
    assign op_dir_d = (wr_any && ACC_SEL == `PAFS_SEL_OP_DIR) ? wr_data[3:0] : op_dir_q;
    assign adsel_d  = (wr_any && ACC_SEL == `PAFS_SEL_ADSEL) ? wr_data[3:0] : adsel_q;
    assign chsel_d  = (wr_any && ACC_SEL == `PAFS_SEL_CHSEL) ? wr_data[2:0] : chsel_q;
    assign clkm_d   = (wr_any && ACC_SEL == `PAFS_SEL_CLKMODE)
                      ? (wr_data & `PAFS_CLKMODE_WMASK) : clkm_q;

    assign ana_mask  = adsel_decode(adsel_q); // [RQ3]
    assign adsel_bad = adsel_q > `PAFS_ADSEL_ALLDIG;
    generate
        for (genvar g = 0; g < 8; g++) begin : g_tgt
            assign ana_tgt[g] = ana_mask[g] & pa_dir_q[g] & (chsel_q == 3'(g)); // [RQ4] [RQ5]
        end
    endgenerate

    // Oscillation mode takes both pins; external clock mode takes only the oscillator output pin.
    assign osc_main = clkm_q[`PAFS_CLKM_OSC] & ~clkm_q[`PAFS_CLKM_EXT];
    assign ext_main = clkm_q[`PAFS_CLKM_OSC] & clkm_q[`PAFS_CLKM_EXT];
    assign osc_sub  = clkm_q[`PAFS_CLKM_OSCS] & ~clkm_q[`PAFS_CLKM_EXTS];
    assign ext_sub  = clkm_q[`PAFS_CLKM_OSCS] & clkm_q[`PAFS_CLKM_EXTS];
    assign osc_own[`PAFS_OSC_MAIN_IN]  = osc_main; // [RQ8]
    assign osc_own[`PAFS_OSC_MAIN_OUT] = osc_main | ext_main; // [RQ8]
    assign osc_own[`PAFS_OSC_SUB_IN]   = osc_sub; // [RQ8]
    assign osc_own[`PAFS_OSC_SUB_OUT]  = osc_sub | ext_sub; // [RQ8]

    generate
        for (genvar g = 0; g < 8; g++) begin : g_pa
            pafs_pin_cell u_cell (
                .clk      (CORE_CLK),
                .rst_n    (RSTN),
                .latch_wr (wr_any && ACC_SEL == `PAFS_SEL_PA_DATA),
                .latch_d  (wr_data[g]),
                .dir_in   (pa_dir_q[g]),
                .owned    (ana_mask[g]), // [RQ3] [RQ5]
                .alt_en   (PA_ALT_EN[g]),
                .alt_val  (PA_ALT_OUT[g]),
                .alt_and  (PA_ALT_AND_MASK[g]),
                .pin_i    (PA_PIN_I[g]),
                .pin_o    (PA_PIN_O[g]),
                .pin_oe   (PA_PIN_OE[g]),
                .rd_val   (pa_rd[g])
            );
        end
        for (genvar g = 0; g < 4; g++) begin : g_op
            pafs_pin_cell u_cell (
                .clk      (CORE_CLK),
                .rst_n    (RSTN),
                .latch_wr (wr_any && ACC_SEL == `PAFS_SEL_OP_DATA),
                .latch_d  (wr_data[g]),
                .dir_in   (op_dir_q[g]),
                .owned    (osc_own[g]), // [RQ8]
                .alt_en   (1'b0),
                .alt_val  (1'b0),
                .alt_and  (1'b0),
                .pin_i    (OP_PIN_I[g]),
                .pin_o    (OP_PIN_O[g]),
                .pin_oe   (OP_PIN_OE[g]),
                .rd_val   (op_rd[g])
            );
        end
    endgenerate

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            pa_dir_q <= `PAFS_PA_DIR_RST;
            op_dir_q <= `PAFS_OP_DIR_RST;
            adsel_q  <= `PAFS_ADSEL_RST;
            chsel_q  <= `PAFS_CHSEL_RST;
            clkm_q   <= `PAFS_CLKMODE_RST; // [RQ7]
        end else begin
            pa_dir_q <= pa_dir_d;
            op_dir_q <= op_dir_d;
            adsel_q  <= adsel_d;
            chsel_q  <= chsel_d;
            clkm_q   <= clkm_d;
        end
    end

    // Status outputs are registered so they never glitch while settings change.
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            rdata_q   <= `PAFS_RDATA_RST;
            ana_en_q  <= 8'h00;
            ana_tgt_q <= 8'h00;
            ana_err_q <= 1'b0;
        end else begin
            rdata_q   <= cur_rd; // [RQ9]
            ana_en_q  <= ana_mask & pa_dir_q; // [RQ5]
            ana_tgt_q <= ana_tgt; // [RQ4]
            ana_err_q <= adsel_bad | (|(ana_mask & ~pa_dir_q)); // [RQ5]
        end
    end

    assign ACC_RDATA       = rdata_q;
    assign ANA_INPUT_EN    = ana_en_q;
    assign ANA_CONV_TGT    = ana_tgt_q;
    assign ANA_CFG_ERR     = ana_err_q;
    assign CLK_MAIN_OSC_EN = osc_main;
    assign CLK_MAIN_EXT_EN = ext_main;
    assign CLK_SUB_OSC_EN  = osc_sub;
    assign CLK_SUB_EXT_EN  = ext_sub;
    assign CLK_GAIN_HIGH   = clkm_q[`PAFS_CLKM_GAIN];

endmodule // pafs_top

`default_nettype wire

// ==== pafs_props.sv ====
// Concurrent checks on the port pin multiplexer ports.
`default_nettype none
module pafs_props
    import pafs_pkg::*;
#(
    parameter logic [7:0] PA_ALT_AND_MASK = 8'h00
)
(
    input wire logic       CORE_CLK,
    input wire logic       RSTN,
    input wire logic       ACC_WR,
    input wire logic       ACC_BIT,
    input wire logic [2:0] ACC_SEL,
    input wire logic [7:0] ACC_WDATA,
    input wire logic [7:0] ACC_RDATA,
    input wire logic [7:0] PA_ALT_EN,
    input wire logic [7:0] PA_ALT_OUT,
    input wire logic [7:0] PA_PIN_O,
    input wire logic [7:0] PA_PIN_OE,
    input wire logic [3:0] OP_PIN_O,
    input wire logic [3:0] OP_PIN_OE,
    input wire logic [7:0] ANA_INPUT_EN,
    input wire logic [7:0] ANA_CONV_TGT,
    input wire logic       ANA_CFG_ERR,
    input wire logic       CLK_MAIN_OSC_EN,
    input wire logic       CLK_MAIN_EXT_EN,
    input wire logic       CLK_SUB_OSC_EN,
    input wire logic       CLK_SUB_EXT_EN,
    input wire logic       CLK_GAIN_HIGH
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    logic       wr_cm, wr_pa, wr_ad;
    logic [4:0] cm_exp;
    assign wr_cm = ACC_WR && !ACC_BIT && ACC_SEL == PAFS_CLKMODE;
    assign wr_pa = ACC_WR && !ACC_BIT && ACC_SEL == PAFS_PA_DATA;
    assign wr_ad = ACC_WR && !ACC_BIT && ACC_SEL == PAFS_ADSEL;
    assign cm_exp = {ACC_WDATA[7:6] == 2'b01, ACC_WDATA[7:6] == 2'b11,
                     ACC_WDATA[5:4] == 2'b01, ACC_WDATA[5:4] == 2'b11, ACC_WDATA[0]};
    property p_reset_state;
        $rose(RSTN) |-> ACC_RDATA == 8'h00 && PA_PIN_OE == 8'h00 && OP_PIN_OE == 4'h0
            && !CLK_MAIN_OSC_EN && !CLK_MAIN_EXT_EN && !CLK_GAIN_HIGH;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    property p_off_low;
        (PA_PIN_O & ~PA_PIN_OE) == 8'h00 && (OP_PIN_O & ~OP_PIN_OE) == 4'h0;
    endproperty
    a_off_low: assert property (p_off_low) else $error("pin level while buffer off");
    property p_latch_drive;
        wr_pa |=> ((PA_PIN_O ^ $past(ACC_WDATA)) & PA_PIN_OE & ~PA_ALT_EN) == 8'h00;
    endproperty
    a_latch_drive: assert property (p_latch_drive) else $error("latch not on pin");
    property p_alt_or;
        (PA_ALT_EN & PA_PIN_OE & ~PA_ALT_AND_MASK & PA_ALT_OUT & ~PA_PIN_O) == 8'h00;
    endproperty
    a_alt_or: assert property (p_alt_or) else $error("peripheral output lost");
    property p_clk_decode;
        wr_cm |=> {CLK_MAIN_OSC_EN, CLK_MAIN_EXT_EN, CLK_SUB_OSC_EN, CLK_SUB_EXT_EN,
                   CLK_GAIN_HIGH} == $past(cm_exp);
    endproperty
    a_clk_decode: assert property (p_clk_decode) else $error("clock mode decode");
    property p_clk_readback;
        wr_cm ##1 ACC_SEL == PAFS_CLKMODE |=> ACC_RDATA == ($past(ACC_WDATA, 2) & 8'hf1);
    endproperty
    a_clk_readback: assert property (p_clk_readback) else $error("clock mode read");
    property p_osc_owned;
        !(CLK_MAIN_OSC_EN && |OP_PIN_OE[1:0]) && !(CLK_MAIN_EXT_EN && OP_PIN_OE[1])
            && !(CLK_SUB_OSC_EN && |OP_PIN_OE[3:2]) && !(CLK_SUB_EXT_EN && OP_PIN_OE[3]);
    endproperty
    a_osc_owned: assert property (p_osc_owned) else $error("oscillator pin driven");
    property p_conv;
        $onehot0(ANA_CONV_TGT) && (ANA_CONV_TGT & ~ANA_INPUT_EN) == 8'h00;
    endproperty
    a_conv: assert property (p_conv) else $error("bad conversion target");
    property p_ana_undriven;
        (ANA_INPUT_EN & PA_PIN_OE) == 8'h00;
    endproperty
    a_ana_undriven: assert property (p_ana_undriven) else $error("analog pin driven");
    property p_sel_err;
        wr_ad && ACC_WDATA[3:0] > 4'h8 |=> ##1 ANA_CFG_ERR;
    endproperty
    a_sel_err: assert property (p_sel_err) else $error("prohibited code unflagged");
    c_bitop: cover property (ACC_BIT && ACC_SEL == PAFS_PA_DATA);
    c_err: cover property (ANA_CFG_ERR);
    c_ext: cover property (CLK_MAIN_EXT_EN);
    c_conv: cover property (|ANA_CONV_TGT);
endmodule // pafs_props
bind pafs_top pafs_props #(.PA_ALT_AND_MASK(PA_ALT_AND_MASK)) u_props (.*);
`default_nettype wire

// ==== pafs_pins.sv ====
// Outside circuitry: each pin shows the block's drive, else the outside level.
`default_nettype none
module pafs_pins (
    input  wire logic [7:0] pa_o,
    input  wire logic [7:0] pa_oe,
    input  wire logic [7:0] pa_ext,
    output logic      [7:0] pa_i,
    input  wire logic [3:0] op_o,
    input  wire logic [3:0] op_oe,
    input  wire logic [3:0] op_ext,
    output logic      [3:0] op_i
);
    timeunit 1ns;
    timeprecision 1ns;
    assign pa_i = (pa_o & pa_oe) | (pa_ext & ~pa_oe);
    assign op_i = (op_o & op_oe) | (op_ext & ~op_oe);
endmodule // pafs_pins
`default_nettype wire

// ==== pafs_top_test.sv ====
// Self-checking bench for the port pin multiplexer.
`default_nettype none
module pafs_top_test import pafs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rstn, wr, bop, bv, err, mosc, mext, sosc, sext, gain;
    logic [2:0] sel, bn;
    logic [7:0] wd, rd, alt_en, alt_out, pa_i, pa_o, pa_oe, pa_ext, ana_in, tgt;
    logic [3:0] op_i, op_o, op_oe, op_ext;
    int         num_errors = 0, n_checks = 0, cyc = 0;
    localparam logic [7:0] RST_TAB [8] = '{8'h00, 8'hff, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00,
                                           8'h00};
    localparam logic [7:0] CM_TAB [6] = '{8'h40, 8'hc0, 8'h10, 8'h30, 8'h01, 8'h80};
    localparam logic [7:0] DEC_TAB [6] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};
    localparam logic [7:0] OE_TAB [6] = '{8'hcc, 8'hdd, 8'h33, 8'h77, 8'hff, 8'hff};
    // Pin 1 combines by AND so that both merge paths of the pin driver are exercised.
    pafs_top #(.PA_ALT_AND_MASK(8'h02)) uut (.CORE_CLK(clk), .RSTN(rstn), .ACC_WR(wr),
        .ACC_BIT(bop), .ACC_SEL(sel),
        .ACC_WDATA(wd), .ACC_BITNUM(bn), .ACC_BITVAL(bv), .ACC_RDATA(rd),
        .PA_ALT_EN(alt_en), .PA_ALT_OUT(alt_out), .PA_PIN_I(pa_i), .PA_PIN_O(pa_o),
        .PA_PIN_OE(pa_oe), .OP_PIN_I(op_i), .OP_PIN_O(op_o), .OP_PIN_OE(op_oe),
        .ANA_INPUT_EN(ana_in), .ANA_CONV_TGT(tgt), .ANA_CFG_ERR(err),
        .CLK_MAIN_OSC_EN(mosc), .CLK_MAIN_EXT_EN(mext), .CLK_SUB_OSC_EN(sosc),
        .CLK_SUB_EXT_EN(sext), .CLK_GAIN_HIGH(gain));
    pafs_pins far (.pa_o(pa_o), .pa_oe(pa_oe), .pa_ext(pa_ext), .pa_i(pa_i),
        .op_o(op_o), .op_oe(op_oe), .op_ext(op_ext), .op_i(op_i));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        sel <= s;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bset(input logic [2:0] s, input logic [2:0] b, input logic v);
        @(posedge clk);
        sel <= s;
        bn <= b;
        bv <= v;
        bop <= 1'b1;
        @(posedge clk);
        bop <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] s, input logic [7:0] e);
        @(posedge clk);
        sel <= s;
        tick(2);
        chk("read data", e, rd);
    endtask
    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) rchk(3'(i), RST_TAB[i]);
        chk("pin enable", 8'h00, {op_oe, pa_oe[3:0] | pa_oe[7:4]});
        $display("test reset done");
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // The limit sits far above the fewer than two hundred cycles the tests need.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        {wr, bop, bv, sel, bn, wd, alt_en, alt_out, pa_ext, op_ext} = '0;
        rstn = 1'b0;
        do_reset();
        @(posedge clk);
        pa_ext <= 8'hfe;
        wreg(PAFS_ADSEL, 8'h08);
        wreg(PAFS_PA_DIR, 8'hfe);
        wreg(PAFS_PA_DATA, 8'h00);
        bset(PAFS_PA_DATA, 3'h0, 1'b1);
        rchk(PAFS_PA_DATA, 8'hff);
        wreg(PAFS_PA_DIR, 8'h00);
        rchk(PAFS_PA_DATA, 8'hff);
        chk("pin drive", 8'hff, pa_o);
        bset(PAFS_PA_DATA, 3'h7, 1'b0);
        rchk(PAFS_PA_DATA, 8'h7f);
        chk("pin drive", 8'h7f, pa_o);
        wreg(PAFS_PA_DIR, 8'hfe);
        wreg(PAFS_PA_DATA, 8'h00);
        rchk(PAFS_PA_DATA, 8'hfe);
        chk("pin enable", 8'h01, pa_oe);
        chk("pin drive", 8'h00, pa_o);
        wreg(PAFS_PA_DIR, 8'hfc);
        wreg(PAFS_PA_DATA, 8'h02);
        @(posedge clk);
        alt_en <= 8'h03;
        alt_out <= 8'h01;
        tick(1);
        chk("alt drive", 8'h01, pa_o);
        @(posedge clk);
        alt_out <= 8'h02;
        tick(1);
        chk("alt drive", 8'h02, pa_o);
        $display("test port done");
        wreg(PAFS_ADSEL, 8'h04);
        wreg(PAFS_CHSEL, 8'h05);
        tick(2);
        chk("analog input", 8'hf0, ana_in);
        chk("conversion", 8'h20, tgt);
        chk("config error", 8'h00, {7'h0, err});
        wreg(PAFS_CHSEL, 8'h02);
        tick(2);
        chk("conversion", 8'h00, tgt);
        chk("analog input", 8'hf0, ana_in);
        wreg(PAFS_PA_DIR, 8'hee);
        tick(2);
        chk("config error", 8'h01, {7'h0, err});
        chk("pin enable", 8'h01, pa_oe);
        wreg(PAFS_PA_DIR, 8'hfe);
        wreg(PAFS_ADSEL, 8'h09);
        tick(2);
        chk("config error", 8'h01, {7'h0, err});
        chk("analog input", 8'h00, ana_in);
        $display("test analog done");
        wreg(PAFS_OP_DATA, 8'h0f);
        wreg(PAFS_OP_DIR, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wreg(PAFS_CLKMODE, CM_TAB[i]);
            rchk(PAFS_CLKMODE, CM_TAB[i]);
            chk("clock decode", DEC_TAB[i], {3'h0, mosc, mext, sosc, sext, gain});
            chk("osc pins", OE_TAB[i], {op_oe, op_o});
        end
        wreg(PAFS_CLKMODE, 8'hff);
        rchk(PAFS_CLKMODE, 8'hf1);
        $display("test clock done");
        do_reset();
        print_verdict();
    end
endmodule // pafs_top_test
`default_nettype wire
